// >>> rtl/pio_cfg_pkg.sv
// Constants and types for the parallel I/O pattern configuration block.
// Assumes the configuration values arrive from a nonvolatile store.
package pio_cfg_pkg;
	localparam int PATTERN_W = 3;
	localparam logic [2:0] PATTERN_RESET = 3'h0;
	localparam logic [2:0] PATTERN_MAX = 3'h5;
	localparam logic SERVO_DIS_RESET = 1'b1;
	localparam logic PAUSE_DIS_RESET = 1'b0;
	localparam int PIO_IN_W = 16;
	localparam int PIO_OUT_W = 16;
	localparam int POS_W = 16;
	localparam int POINT_W = 6;
	localparam int COUNT_W = 7;
	localparam int DIRECT_TARGETS = 4;
	localparam logic [6:0] POINTS_STD = 7'h10;
	localparam logic [6:0] POINTS_WIDE = 7'h40;
	localparam logic [6:0] POINTS_AIR = 7'h04;
	localparam logic [15:0] PIO_OUT_RESET = 16'h0000;
	typedef enum logic [2:0] {
		PAT_LEGACY,
		PAT_STANDARD,
		PAT_WIDE,
		PAT_TWO_ZONE,
		PAT_TEACH,
		PAT_AIR_CYL
	} pattern_e;
endpackage

// >>> rtl/pio_zone_window.sv
// Registered window comparator for the second zone output.
// Assumes the boundaries are stable configuration values.
`timescale 1ns/1ns
module pio_zone_window
	import pio_cfg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [POS_W-1:0] i_position,
	input wire logic [POS_W-1:0] i_lo,
	input wire logic [POS_W-1:0] i_hi,
	output logic o_in_zone
);
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_in_zone <= 1'b0;
		end
		else
		begin
			o_in_zone <= (i_position >= i_lo) && (i_position <= i_hi);
		end
	end
endmodule // pio_zone_window

// >>> rtl/pio_pattern_config.sv
// Parallel I/O pattern decoder between the PLC pins and the motion core.
// Assumes configuration inputs are static and on the core clock domain.
`timescale 1ns/1ns
// Functional notes
// - Six signal sets chosen by selection zero to five; default zero.
// - Selection zero keeps the earlier generation's pin arrangement.
// - Selection one: sixteen points, home, servo-on, reset, moving, ready.
// - Selection two gives sixty-four points; no servo-on, ready or zone.
// - Selection three drives two zones, no moving; zone two from boundaries.
// - Selection four adds teaching mode switched by an input, with completion.
// - Selection five gives four direct commands with own complete outputs.
// - Servo-on input honoured when disable is zero, ignored when one.
// - Selections zero and two never energise servo unless disable is one.
// - Pause input is active low; must be held high for any motion.
// - Pause disable zero uses the input; one makes it unnecessary.
// - Position table and parameters come from nonvolatile storage.
module pio_pattern_config
	import pio_cfg_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RESETN,
	input wire logic [pio_cfg_pkg::PATTERN_W-1:0] I_PATTERN_SEL,
	input wire logic I_SERVO_ON_DIS,
	input wire logic I_PAUSE_DIS,
	input wire logic [pio_cfg_pkg::POS_W-1:0] I_ZONE2_LO,
	input wire logic [pio_cfg_pkg::POS_W-1:0] I_ZONE2_HI,
	input wire logic [pio_cfg_pkg::PIO_IN_W-1:0] I_PIO_IN,
	input wire logic [pio_cfg_pkg::POS_W-1:0] I_POSITION,
	input wire logic I_MOVING,
	input wire logic I_READY,
	input wire logic I_ZONE1,
	input wire logic I_POS_DONE,
	input wire logic [pio_cfg_pkg::POINT_W-1:0] I_DONE_POINT,
	output logic [pio_cfg_pkg::PIO_OUT_W-1:0] O_PIO_OUT,
	output logic O_SERVO_EN,
	output logic O_MOTION_PERMIT,
	output logic O_START,
	output logic [pio_cfg_pkg::POINT_W-1:0] O_POS_SEL,
	output logic O_HOME,
	output logic O_ALARM_RESET,
	output logic O_TEACH_MODE,
	output logic O_JOG_FWD,
	output logic O_JOG_REV,
	output logic O_TEACH_WRITE,
	output logic [pio_cfg_pkg::COUNT_W-1:0] O_POINT_COUNT
);
	import pio_cfg_pkg::*;

	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [PIO_IN_W-1:0] in_meta_q;
	logic [PIO_IN_W-1:0] in_sync_q;
	pattern_e pattern_q;
	logic servo_dis_q;
	logic pause_dis_q;
	logic cfg_loaded_q;
	logic [POINT_W-1:0] sel_lvl;
	logic start_lvl, home_lvl, son_lvl, has_son, clr_lvl, pause_n_lvl;
	logic mode_lvl, jogf_lvl, jogr_lvl, wr_lvl;
	logic [DIRECT_TARGETS-1:0] direct_lvl;
	logic start_q, home_q, clr_q, wr_q;
	logic [DIRECT_TARGETS-1:0] direct_q;
	logic permit;
	logic teach_mode_q;
	logic zone2;
	logic [DIRECT_TARGETS-1:0] target_done;
	logic [PIO_OUT_W-1:0] out_d;
	logic [POINT_W-1:0] direct_sel;
	logic direct_hit;

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// Pins come from the PLC, asynchronous to the core clock.
	always_ff @(posedge I_CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			in_meta_q <= '0;
			in_sync_q <= '0;
		end
		else
		begin
			in_meta_q <= I_PIO_IN;
			in_sync_q <= in_meta_q;
		end
	end

	// Configuration is caught once after reset release, so a new selection
	// written to storage mid-run cannot remap the pins under a moving axis.
	always_ff @(posedge I_CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pattern_q <= pattern_e'(PATTERN_RESET);
			servo_dis_q <= SERVO_DIS_RESET;
			pause_dis_q <= PAUSE_DIS_RESET;
			cfg_loaded_q <= 1'b0;
		end
		else if (!cfg_loaded_q)
		begin
			// Values are read from the nonvolatile parameter store.
			if (I_PATTERN_SEL > PATTERN_MAX)
				pattern_q <= pattern_e'(PATTERN_RESET);
			else
				pattern_q <= pattern_e'(I_PATTERN_SEL);
			servo_dis_q <= I_SERVO_ON_DIS;
			pause_dis_q <= I_PAUSE_DIS;
			cfg_loaded_q <= 1'b1;
		end
	end

	// Input pin decode; a function without a pin stays at zero.
	always_comb
	begin
		sel_lvl = '0;
		start_lvl = 1'b0;
		home_lvl = 1'b0;
		son_lvl = 1'b0;
		has_son = 1'b0;
		clr_lvl = 1'b0;
		pause_n_lvl = 1'b0;
		mode_lvl = 1'b0;
		jogf_lvl = 1'b0;
		jogr_lvl = 1'b0;
		wr_lvl = 1'b0;
		direct_lvl = '0;
		unique case (pattern_q)
			PAT_LEGACY:
			begin
				sel_lvl = {2'b00, in_sync_q[3:0]};
				start_lvl = in_sync_q[4];
				pause_n_lvl = in_sync_q[5];
			end
			PAT_STANDARD, PAT_TWO_ZONE, PAT_TEACH:
			begin
				sel_lvl = {2'b00, in_sync_q[3:0]};
				start_lvl = in_sync_q[4];
				home_lvl = in_sync_q[5];
				son_lvl = in_sync_q[6];
				has_son = 1'b1;
				clr_lvl = in_sync_q[7];
				pause_n_lvl = in_sync_q[8];
				if (pattern_q == PAT_TEACH)
				begin
					mode_lvl = in_sync_q[9];
					jogf_lvl = in_sync_q[10];
					jogr_lvl = in_sync_q[11];
					wr_lvl = in_sync_q[12];
				end
			end
			PAT_WIDE:
			begin
				sel_lvl = in_sync_q[5:0];
				start_lvl = in_sync_q[6];
				home_lvl = in_sync_q[7];
				clr_lvl = in_sync_q[8];
				pause_n_lvl = in_sync_q[9];
			end
			PAT_AIR_CYL:
			begin
				direct_lvl = in_sync_q[3:0];
				home_lvl = in_sync_q[4];
				son_lvl = in_sync_q[5];
				has_son = 1'b1;
				clr_lvl = in_sync_q[6];
				pause_n_lvl = in_sync_q[7];
			end
		endcase
	end

	assign permit = pause_dis_q | pause_n_lvl;

	// Lowest-numbered rising direct command wins if two rise together.
	always_comb
	begin
		direct_sel = '0;
		direct_hit = 1'b0;
		for (int k = DIRECT_TARGETS - 1; k >= 0; k--)
		begin
			if (direct_lvl[k] && !direct_q[k])
			begin
				direct_sel = POINT_W'(k);
				direct_hit = 1'b1;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			start_q <= 1'b0;
			home_q <= 1'b0;
			clr_q <= 1'b0;
			wr_q <= 1'b0;
			direct_q <= '0;
		end
		else
		begin
			start_q <= start_lvl;
			home_q <= home_lvl;
			clr_q <= clr_lvl;
			wr_q <= wr_lvl;
			direct_q <= direct_lvl;
		end
	end

	// Mode changes are held off while moving so a jog never cuts a move.
	always_ff @(posedge I_CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
			teach_mode_q <= 1'b0;
		else if (pattern_q != PAT_TEACH)
			teach_mode_q <= 1'b0;
		else if (!I_MOVING)
			teach_mode_q <= mode_lvl;
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			O_SERVO_EN <= 1'b0;
			O_MOTION_PERMIT <= 1'b0;
			O_START <= 1'b0;
			O_POS_SEL <= '0;
			O_HOME <= 1'b0;
			O_ALARM_RESET <= 1'b0;
			O_TEACH_MODE <= 1'b0;
			O_JOG_FWD <= 1'b0;
			O_JOG_REV <= 1'b0;
			O_TEACH_WRITE <= 1'b0;
		end
		else
		begin
			// Patterns without the pin can only turn on via the disable.
			O_SERVO_EN <= servo_dis_q | (has_son & son_lvl);
			O_MOTION_PERMIT <= permit;
			O_START <= 1'b0;
			if (pattern_q == PAT_AIR_CYL)
			begin
				if (direct_hit && permit)
				begin
					O_START <= 1'b1;
					O_POS_SEL <= direct_sel;
				end
			end
			else if (start_lvl && !start_q && permit && !teach_mode_q)
			begin
				O_START <= 1'b1;
				O_POS_SEL <= sel_lvl;
			end
			O_HOME <= home_lvl & ~home_q & permit;
			O_ALARM_RESET <= clr_lvl & ~clr_q;
			O_TEACH_MODE <= teach_mode_q;
			O_JOG_FWD <= teach_mode_q & jogf_lvl & permit;
			O_JOG_REV <= teach_mode_q & jogr_lvl & permit;
			O_TEACH_WRITE <= teach_mode_q & wr_lvl & ~wr_q;
		end
	end

	pio_zone_window u_zone2
	(
		.i_clk(I_CORE_CLK),
		.i_rst_n(rst_n),
		.i_position(I_POSITION),
		.i_lo(I_ZONE2_LO),
		.i_hi(I_ZONE2_HI),
		.o_in_zone(zone2)
	);

	genvar g;
	generate
		for (g = 0; g < DIRECT_TARGETS; g++)
		begin : g_target
			assign target_done[g] = I_POS_DONE &&
				(I_DONE_POINT == POINT_W'(g));
		end
	endgenerate

	always_comb
	begin
		out_d = '0;
		unique case (pattern_q)
			PAT_LEGACY:
			begin
				out_d[3:0] = I_DONE_POINT[3:0];
				out_d[4] = I_POS_DONE;
				out_d[5] = I_ZONE1;
			end
			PAT_STANDARD, PAT_TWO_ZONE, PAT_TEACH:
			begin
				out_d[3:0] = I_DONE_POINT[3:0];
				out_d[4] = I_POS_DONE;
				out_d[7] = I_READY;
				if (pattern_q == PAT_STANDARD)
				begin
					out_d[5] = I_ZONE1;
					out_d[6] = I_MOVING;
				end
				else if (pattern_q == PAT_TWO_ZONE)
				begin
					out_d[5] = I_ZONE1;
					out_d[6] = zone2;
				end
				else
				begin
					out_d[6] = I_MOVING;
					out_d[8] = teach_mode_q;
				end
			end
			PAT_WIDE:
			begin
				out_d[5:0] = I_DONE_POINT;
				out_d[6] = I_POS_DONE;
				out_d[7] = I_MOVING;
			end
			PAT_AIR_CYL:
			begin
				out_d[3:0] = target_done;
				out_d[4] = I_MOVING;
				out_d[5] = I_READY;
			end
		endcase
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			O_PIO_OUT <= PIO_OUT_RESET;
			O_POINT_COUNT <= '0;
		end
		else
		begin
			O_PIO_OUT <= out_d;
			unique case (pattern_q)
				PAT_WIDE: O_POINT_COUNT <= POINTS_WIDE;
				PAT_AIR_CYL: O_POINT_COUNT <= POINTS_AIR;
				default: O_POINT_COUNT <= POINTS_STD;
			endcase
		end
	end

	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!rst_n);

	sequence legacy_start_s;
		pattern_q == PAT_LEGACY && start_lvl && !start_q && permit;
	endsequence

	pattern_range_a: assert property (pattern_q <= PATTERN_MAX)
		else $error("pattern selection out of range");
	legacy_map_a: assert property (legacy_start_s |=> O_START &&
		O_POS_SEL == {2'b00, $past(in_sync_q[3:0])})
		else $error("legacy start mapping wrong");
	std_points_a: assert property (pattern_q == PAT_STANDARD |=>
		O_POINT_COUNT == POINTS_STD)
		else $error("standard point count wrong");
	wide_no_ready_a: assert property (pattern_q == PAT_WIDE |=>
		O_PIO_OUT[15:8] == 8'h00 && O_POINT_COUNT == POINTS_WIDE)
		else $error("wide pattern drives removed outputs");
	zone_two_a: assert property (pattern_q == PAT_TWO_ZONE |=>
		O_PIO_OUT[6] == $past(zone2))
		else $error("second zone output wrong");
	teach_only_a: assert property (pattern_q != PAT_TEACH |=>
		!O_TEACH_MODE && !O_JOG_FWD && !O_JOG_REV)
		else $error("teaching active outside teach pattern");
	air_target_a: assert property (pattern_q == PAT_AIR_CYL && O_START
		|-> O_POS_SEL < 6'h04)
		else $error("air cylinder target beyond four");
	servo_dis_a: assert property (servo_dis_q |=> O_SERVO_EN)
		else $error("servo not on with input disabled");
	no_son_a: assert property (!servo_dis_q && (pattern_q == PAT_LEGACY ||
		pattern_q == PAT_WIDE) |=> !O_SERVO_EN)
		else $error("servo on without servo-on pin");
	pause_hold_a: assert property (!pause_dis_q && !pause_n_lvl |=>
		!O_MOTION_PERMIT && !O_START && !O_HOME)
		else $error("motion while paused");
	pause_dis_a: assert property (pause_dis_q |=> O_MOTION_PERMIT)
		else $error("pause blocks motion while disabled");
	cfg_stable_a: assert property (cfg_loaded_q |=> $stable(pattern_q) &&
		$stable(servo_dis_q) && $stable(pause_dis_q))
		else $error("configuration changed during run");
endmodule // pio_pattern_config

// >>> verification/plc_model.sv
// PLC partner that drives the parallel input pins and counts starts.
// Assumes the bench asks for pin levels and reads the start count.
`timescale 1ns/1ns
module plc_model
(
	input wire logic i_clk,
	input wire logic [15:0] i_pins,
	input wire logic i_start,
	output logic [15:0] o_pio_in,
	output logic [7:0] o_start_cnt
);
	initial
	begin
		o_pio_in = 16'h0000;
		o_start_cnt = 8'h00;
	end
	// Pins move just after an edge and hold, pause held where asked.
	always @(posedge i_clk)
	begin
		o_pio_in <= i_pins;
	end
	// Counting pulses avoids sampling a one-cycle strobe by hand.
	always @(posedge i_clk)
	begin
		if (i_start === 1'b1)
			o_start_cnt <= o_start_cnt + 8'h01;
	end
endmodule // plc_model

// >>> verification/tb.sv
// Self-checking bench for the parallel I/O pattern block.
// Assumes configuration is stable across each restart.
`timescale 1ns/1ns
module tb;
	import pio_cfg_pkg::*;
	typedef struct {
		logic [2:0] sel;
		logic sd;
		logic pd;
		logic mv;
		logic [5:0] dp;
		logic [15:0] pin;
		logic [15:0] out;
		logic sv;
		logic pm;
		logic [6:0] cnt;
	} row_s;
	row_s rows [8];
	logic clk, rstn, sdis, pdis, moving, servo, permit, start, home;
	logic [2:0] sel;
	logic [15:0] pins, pio_in, pio_out, pos;
	logic [5:0] dpt, pos_sel;
	logic [6:0] cnt;
	logic [7:0] start_cnt, b, h, c;
	logic [7:0] home_cnt = 8'h00;
	logic [7:0] clr_cnt = 8'h00;
	logic [7:0] wr_cnt = 8'h00;
	logic teach, jf, jr, clr, wr;
	int errors = 0;
	int checks = 0;
	plc_model u_plc_model (.i_clk(clk), .i_pins(pins), .i_start(start),
		.o_pio_in(pio_in), .o_start_cnt(start_cnt));
	pio_pattern_config u_pio_pattern_config (
		.I_CORE_CLK(clk), .I_RESETN(rstn), .I_PATTERN_SEL(sel),
		.I_SERVO_ON_DIS(sdis), .I_PAUSE_DIS(pdis),
		.I_ZONE2_LO(16'h0100), .I_ZONE2_HI(16'h0200),
		.I_PIO_IN(pio_in), .I_POSITION(pos), .I_MOVING(moving),
		.I_READY(1'b1), .I_ZONE1(1'b1), .I_POS_DONE(1'b1),
		.I_DONE_POINT(dpt), .O_PIO_OUT(pio_out), .O_SERVO_EN(servo),
		.O_MOTION_PERMIT(permit), .O_START(start), .O_POS_SEL(pos_sel),
		.O_HOME(home), .O_ALARM_RESET(clr), .O_TEACH_MODE(teach),
		.O_JOG_FWD(jf), .O_JOG_REV(jr), .O_TEACH_WRITE(wr),
		.O_POINT_COUNT(cnt));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One-cycle strobes are counted so no check has to land on the pulse.
	always @(posedge clk)
	begin
		if (home === 1'b1)
			home_cnt <= home_cnt + 8'h01;
		if (clr === 1'b1)
			clr_cnt <= clr_cnt + 8'h01;
		if (wr === 1'b1)
			wr_cnt <= wr_cnt + 8'h01;
	end
	task automatic end_sim;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic restart(input logic [2:0] s, input logic d,
		input logic p);
		@(posedge clk);
		rstn <= 1'b0;
		sel <= s;
		sdis <= d;
		pdis <= p;
		tick(2);
		rstn <= 1'b1;
		tick(6);
	endtask
	task automatic drive(input logic [15:0] p, input int n);
		@(posedge clk);
		pins <= p;
		tick(n);
		@(negedge clk);
	endtask
	task automatic wait_start(input logic [7:0] base);
		int i;
		for (i = 0; i < 10 && start_cnt === base; i++)
			tick(1);
		if (i == 10)
		begin
			errors++;
			end_sim();
		end
		@(negedge clk);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		rstn = 1'b0;
		sel = 3'h0;
		sdis = 1'b1;
		pdis = 1'b0;
		pins = 16'h0000;
		moving = 1'b1;
		dpt = 6'h02;
		pos = 16'h0150;
		rows[0] = '{3'h0, 0, 0, 1, 6'h02, 16'h0020, 16'h0032, 0, 1, 7'h10};
		rows[1] = '{3'h1, 0, 0, 1, 6'h02, 16'h0040, 16'h00F2, 1, 0, 7'h10};
		rows[2] = '{3'h2, 1, 0, 1, 6'h22, 16'h0200, 16'h00E2, 1, 1, 7'h40};
		rows[3] = '{3'h3, 0, 1, 0, 6'h02, 16'h0000, 16'h00F2, 0, 1, 7'h10};
		rows[4] = '{3'h4, 0, 0, 1, 6'h02, 16'h0140, 16'h00D2, 1, 1, 7'h10};
		rows[5] = '{3'h5, 0, 0, 1, 6'h02, 16'h00A0, 16'h0034, 1, 1, 7'h04};
		rows[6] = '{3'h6, 1, 1, 1, 6'h02, 16'h0000, 16'h0032, 1, 1, 7'h10};
		rows[7] = '{3'h2, 0, 0, 1, 6'h02, 16'h0200, 16'h00C2, 0, 1, 7'h40};
		foreach (rows[k])
		begin
			@(posedge clk);
			pins <= rows[k].pin;
			moving <= rows[k].mv;
			dpt <= rows[k].dp;
			restart(rows[k].sel, rows[k].sd, rows[k].pd);
			@(negedge clk);
			chk("pio_out", pio_out, rows[k].out);
			chk("servo_en", 16'(servo), 16'(rows[k].sv));
			chk("permit", 16'(permit), 16'(rows[k].pm));
			chk("count", 16'(cnt), 16'(rows[k].cnt));
		end
		@(posedge clk);
		moving <= 1'b0;
		restart(3'h1, 1'b1, 1'b0);
		drive(16'h0105, 4);
		b = start_cnt;
		drive(16'h0115, 0);
		wait_start(b);
		chk("pos_sel", 16'(pos_sel), 16'h0005);
		b = home_cnt;
		drive(16'h0135, 5);
		chk("home", 16'(home_cnt), 16'(b + 8'h01));
		drive(16'h0005, 4);
		b = start_cnt;
		h = home_cnt;
		c = clr_cnt;
		drive(16'h00B5, 8);
		chk("start_cnt", 16'(start_cnt), 16'(b));
		chk("home", 16'(home_cnt), 16'(h));
		chk("alarm_reset", 16'(clr_cnt), 16'(c + 8'h01));
		chk("permit", 16'(permit), 16'h0000);
		// A new selection must not remap pins until the next restart.
		@(posedge clk);
		sel <= 3'h2;
		drive(16'h0105, 4);
		chk("count", 16'(cnt), 16'h0010);
		restart(3'h5, 1'b1, 1'b0);
		drive(16'h0080, 4);
		b = start_cnt;
		drive(16'h008A, 0);
		wait_start(b);
		chk("pos_sel", 16'(pos_sel), 16'h0001);
		restart(3'h4, 1'b1, 1'b0);
		drive(16'h0100, 4);
		drive(16'h0500, 5);
		chk("jog_fwd", 16'(jf), 16'h0000);
		drive(16'h0300, 5);
		chk("teach", 16'(teach), 16'h0001);
		chk("complete", 16'(pio_out[8]), 16'h0001);
		drive(16'h0700, 5);
		chk("jog_fwd", 16'(jf), 16'h0001);
		drive(16'h0B00, 5);
		chk("jog_rev", 16'(jr), 16'h0001);
		b = wr_cnt;
		drive(16'h1300, 5);
		chk("write", 16'(wr_cnt), 16'(b + 8'h01));
		// Upper window edge only: one step above, then on the inclusive upper bound.
		restart(3'h3, 1'b1, 1'b0);
		@(posedge clk);
		pos <= 16'h0201;
		tick(3);
		@(negedge clk);
		chk("zone2", 16'(pio_out[6]), 16'h0000);
		@(posedge clk);
		pos <= 16'h0200;
		tick(3);
		@(negedge clk);
		chk("zone2", 16'(pio_out[6]), 16'h0001);
		@(posedge clk);
		rstn <= 1'b0;
		@(negedge clk);
		chk("pio_out", pio_out, 16'h0000);
		chk("servo_en", 16'(servo), 16'h0000);
		end_sim();
	end
endmodule // tb
